// >>> sim/spcsd_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module spcsd_monitor #(
   parameter int DATA_W = 8
) (
   input wire logic              mclk,
   input wire logic              reset_n,
   input wire logic [7:0]        reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              irq_req,
   input wire logic              sck_out,
   input wire logic              sck_oe_n,
   input wire logic              mosi_out,
   input wire logic              mosi_oe_n,
   input wire logic              miso_oe_n,
   input wire logic              ss_n_in,
   input wire logic              pullup_en
);
   logic [7:0] ctl_reg;
   logic [7:0] cfg_reg;
   logic       quiet;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // shadows of software-owned bits; enable is shadowed but left out of the readback check, a mode fault may clear it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_reg <= spcsd_pkg::CTL_RESET;
      end else if (reg_wr && reg_addr == spcsd_pkg::ADDR_CONTROL) begin
         ctl_reg <= reg_wdata[7:0] & spcsd_pkg::CTL_MASK;
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= 8'h00;
      end else if (reg_wr && reg_addr == spcsd_pkg::ADDR_STATUS) begin
         cfg_reg <= reg_wdata[7:0] & 8'h47;
      end
   end
   assign quiet = !ctl_reg[7] && !ctl_reg[0] && !cfg_reg[6];
   sequence s_no_enables;
      quiet [*3];
   endsequence
   sequence s_deselected;
      (!ctl_reg[5] && ss_n_in) [*4];
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data not zero outside a read");
   a_ctl_readback: assert property (
      $past(reg_rd) && $past(reg_addr) == spcsd_pkg::ADDR_CONTROL
      |-> (reg_rdata[7:0] & 8'hFD) == ($past(ctl_reg) & 8'hFD))
      else $error("control readback wrong");
   a_cfg_readback: assert property (
      $past(reg_rd) && $past(reg_addr) == spcsd_pkg::ADDR_STATUS
      |-> (reg_rdata[7:0] & 8'h47) == $past(cfg_reg))
      else $error("status config readback wrong");
   a_irq_quiet: assert property (s_no_enables |-> !irq_req)
      else $error("request with all enables off");
   a_pins_disabled: assert property (
      (!ctl_reg[1]) [*3] |-> sck_oe_n && mosi_oe_n && miso_oe_n)
      else $error("pin driven while disabled");
   a_pullup_mode: assert property ($stable(ctl_reg[2]) [*2] |-> pullup_en == !ctl_reg[2])
      else $error("pull-up state wrong");
   a_wired_low_only: assert property (
      ctl_reg[2] [*3] |-> (sck_oe_n || !sck_out) && (mosi_oe_n || !mosi_out))
      else $error("open-drain pin driven high");
   a_master_miso_off: assert property (ctl_reg[5] [*3] |-> miso_oe_n)
      else $error("master drives its input line");
   a_slave_no_clock: assert property ((!ctl_reg[5]) [*3] |-> sck_oe_n && mosi_oe_n)
      else $error("slave drives clock or its input");
   a_deselect_float: assert property (s_deselected |-> miso_oe_n)
      else $error("deselected slave drives output");
endmodule
bind spcsd_top spcsd_monitor #(.DATA_W(DATA_W)) spcsd_monitor_i (
   .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req),
   .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
   .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in), .pullup_en(pullup_en));
`default_nettype wire

// >>> sim/spcsd_peer.sv
`timescale 1ns/10ps
`default_nettype none
module spcsd_peer (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic [7:0] reply,
   output logic            miso_drv,
   output logic            miso_en,
   output logic [7:0]      rx_byte
);
   logic [7:0] tx_sh = 8'h00;
   logic [7:0] rx_sh = 8'h00;
   logic       lead;
   initial miso_drv = 1'b0;
   initial rx_byte = 8'h00;
   // released when deselected; the bench wire then shows the pull-up
   assign miso_en = !ss_n;
   // phase 0 needs the first bit out before the first edge
   always @(negedge ss_n) begin
      tx_sh = reply;
      if (!cpha) begin
         miso_drv = tx_sh[7];
         tx_sh = tx_sh << 1;
      end
   end
   always @(sck) begin
      if (!ss_n) begin
         lead = (sck != cpol);
         if (lead != cpha) begin
            rx_sh = {rx_sh[6:0], mosi};
            rx_byte = rx_sh;
         end else begin
            miso_drv = tx_sh[7];
            tx_sh = tx_sh << 1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/tb_spcsd_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t ns: got %0h, expected %0h", $time, g, e); end end
module tb_spcsd_top;
   localparam logic [7:0] A_C = spcsd_pkg::ADDR_CONTROL;
   localparam logic [7:0] A_S = spcsd_pkg::ADDR_STATUS;
   localparam logic [7:0] A_D = spcsd_pkg::ADDR_DATA;
   logic       mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic       ss_n_in = 1'b1, peer_ss_n = 1'b1, cpol = 1'b0, cpha = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reply = 8'h00;
   logic [7:0] v, d, r, ctl, first;
   wire logic [7:0] reg_rdata, peer_rx;
   wire logic  irq_req, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
   wire logic  pullup_en, peer_miso, peer_en;
   int         n_errors = 0, tests_run = 0, cyc = 0, nclk = 0;
   integer     seed = 32'hAC177CF5;
   realtime    t_prev = 0, t_per = 0;
   // undriven lines sit at the pull-up level
   wire        sck_w = sck_oe_n ? 1'b1 : sck_out;
   wire        mosi_w = mosi_oe_n ? 1'b1 : mosi_out;
   wire        miso_w = peer_en ? peer_miso : (miso_oe_n ? 1'b1 : miso_out);
   spcsd_top #(.DATA_W(8)) spcsd_top_i (
      .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq_req(irq_req), .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
      .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
      .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in), .pullup_en(pullup_en));
   spcsd_peer spcsd_peer_i (
      .sck(sck_w), .mosi(mosi_w), .ss_n(peer_ss_n), .cpol(cpol), .cpha(cpha),
      .reply(reply), .miso_drv(peer_miso), .miso_en(peer_en), .rx_byte(peer_rx));
   always #20 mclk = ~mclk;
   always @(posedge sck_w) begin
      if (!peer_ss_n) begin
         nclk++;
         t_per = $realtime - t_prev;
      end
      t_prev = $realtime;
   end
   function automatic int bd(input int c);
      return 2 << (2 * c);
   endfunction
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("[FAIL] %0t ns: run did not finish", $time);
         give_verdict();
      end
   end
   task automatic endt(input string s);
      $display("test %s done, %0d checks so far", s, tests_run);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] dat);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 dat = reg_rdata;
      @(posedge mclk);
   endtask
   task automatic chk_irq(input logic e);
      @(posedge mclk);
      #1 `CHECK(irq_req, e)
      @(posedge mclk);
   endtask
   task automatic poll(input logic [7:0] mask);
      for (int i = 0; i < 1500; i++) begin
         rd(A_S, v);
         if ((v & mask) == mask) break;
      end
   endtask
   task automatic xfer(input logic [7:0] mask);
      d = 8'($random(seed));
      r = 8'($random(seed));
      reply <= r;
      nclk = 0;
      @(posedge mclk);
      peer_ss_n <= 1'b0;
      @(posedge mclk);
      wr(A_D, d);
      poll(mask);
      peer_ss_n <= 1'b1;
      `CHECK(peer_rx, d)
      `CHECK(nclk, 8)
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd(A_C, v);
      `CHECK(v, spcsd_pkg::CTL_RESET)
      rd(A_S, v);
      `CHECK(v, 8'h08)
      rd(8'h3C, v);
      `CHECK(v, 8'h00)
      wr(A_C, 8'h29);
      chk_irq(1'b1);
      wr(A_C, 8'h28);
      chk_irq(1'b0);
      endt("reset and transmit request");
      repeat (6) begin
         ctl = 8'($random(seed));
         wr(A_C, ctl);
         rd(A_C, v);
         `CHECK(v, ctl & spcsd_pkg::CTL_MASK)
         d = 8'($random(seed));
         wr(A_S, d);
         rd(A_S, v);
         `CHECK(v, (d & 8'h47) | 8'h08)
      end
      endt("register readback");
      for (int k = 0; k < 8; k++) begin
         cpol <= k[2];
         cpha <= k[0] ^ k[1];
         ctl = {3'b101, k[2], k[0] ^ k[1], k[0], 2'b10};
         wr(A_S, 8'(k % 4));
         wr(A_C, ctl);
         xfer(8'h80);
         chk_irq(1'b1);
         `CHECK(int'(t_per), bd(k % 4) * 40)
         `CHECK(sck_w, k[2])
         `CHECK(pullup_en, !k[0])
         rd(A_D, v);
         `CHECK(v, r)
         rd(A_S, v);
         `CHECK(v & 8'hA8, 8'h08)
      end
      endt("transfers in every mode and rate");
      wr(A_S, 8'h40);
      wr(A_C, 8'hAA);
      cpol <= 1'b0;
      cpha <= 1'b1;
      xfer(8'h80);
      first = r;
      xfer(8'h20);
      `CHECK(v[5], 1'b1)
      chk_irq(1'b1);
      rd(A_D, v);
      `CHECK(v, first)
      rd(A_S, v);
      `CHECK(v & 8'hA0, 8'h00)
      endt("overflow");
      wr(A_S, 8'h44);
      ss_n_in <= 1'b0;
      poll(8'h10);
      ss_n_in <= 1'b1;
      `CHECK(v[4], 1'b1)
      chk_irq(1'b1);
      rd(A_C, v);
      `CHECK(v[1], 1'b0)
      wr(A_S, 8'h40);
      rd(A_S, v);
      `CHECK(v[4], 1'b1)
      wr(A_C, 8'hAA);
      rd(A_S, v);
      `CHECK(v[4], 1'b0)
      ss_n_in <= 1'b0;
      rd(A_S, v);
      rd(A_S, v);
      `CHECK(v[4], 1'b0)
      rd(A_C, v);
      `CHECK(v[1], 1'b1)
      ss_n_in <= 1'b1;
      endt("mode fault");
      reset_n <= 1'b0;
      @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd(A_D, v);
      `CHECK(v, first)
      rd(A_C, v);
      `CHECK(v, spcsd_pkg::CTL_RESET)
      endt("second reset");
      give_verdict();
   end
endmodule
`default_nettype wire

// >>> src/spcsd_pkg.sv
package spcsd_pkg;
   // register addresses on the plain register port
   localparam logic [7:0] ADDR_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_STATUS  = 8'h11;
   localparam logic [7:0] ADDR_DATA    = 8'h12;
   // control register fields
   localparam int CTL_RX_IRQ_EN  = 7;
   localparam int CTL_MASTER     = 5;
   localparam int CTL_CPOL       = 4;
   localparam int CTL_CPHA       = 3;
   localparam int CTL_WIRED_OR   = 2;
   localparam int CTL_ENABLE     = 1;
   localparam int CTL_TX_IRQ_EN  = 0;
   localparam logic [7:0] CTL_RESET = 8'h28;
   localparam logic [7:0] CTL_MASK  = 8'hBF;
   // status/control register fields
   localparam int STS_RX_FULL    = 7;
   localparam int STS_ERR_IRQ_EN = 6;
   localparam int STS_OVERFLOW   = 5;
   localparam int STS_MODE_FAULT = 4;
   localparam int STS_TX_EMPTY   = 3;
   localparam int STS_MF_EN      = 2;
   localparam int STS_RATE_HI    = 1;
   localparam int STS_RATE_LO    = 0;
   // half-period of the serial clock in bus clocks per rate code
   localparam logic [6:0] HALF_DIV_0 = 7'h01;
   localparam logic [6:0] HALF_DIV_1 = 7'h04;
   localparam logic [6:0] HALF_DIV_2 = 7'h10;
   localparam logic [6:0] HALF_DIV_3 = 7'h40;
   localparam int         BITS_PER_BYTE = 8;
endpackage

// >>> src/spcsd_top.sv
// Contract
// RULE_01: receive interrupt enabled raises request while receiver full is set; reset clears.
// RULE_02: master select 1 means master, 0 slave; reset sets it.
// RULE_03: clock polarity sets idle serial clock level; both ends match; reset clears.
// RULE_04: clock phase picks launch/sample edges; both ends match; reset sets.
// RULE_05: with phase 0 the slave select driver deasserts between bytes.
// RULE_06: wired-or mode makes clock, MOSI, MISO open-drain; otherwise push-pull.
// RULE_07: enable bit turns interface on; clearing it partially resets logic.
// RULE_08: transmit interrupt enabled raises request while transmitter empty is set.
// RULE_09: receiver full sets per received byte; cleared by status then data read.
// RULE_10: error interrupt enable lets mode fault and overflow raise requests.
// RULE_11: overflow sets on new byte before buffer read; old byte kept.
// RULE_12: overflow clears on status read with flag set, then data read.
// RULE_13: slave with fault detect flags fault when select rises mid-transfer.
// RULE_14: master with fault detect flags fault whenever select is low.
// RULE_15: mode fault clears on status read with flag set, then control write.
// RULE_16: transmitter empty sets on handoff to shifter, clears on data write.
// RULE_17: software writes data only when empty; no read-modify-write on data.
// RULE_18: fault detect enable allows fault flag; clearing it keeps flag.
// RULE_19: fault detect off: master ignores select; slave only loses fault flag.
// RULE_20: master rate codes divide bus clock by 2, 8, 32, 128.
// RULE_21: data address reads receive buffer, writes transmit buffer; no reset.
// RULE_22: a transfer swaps one byte each way over eight serial clocks.
// RULE_23: deselected slave floats MISO and ignores serial clock edges.
// RULE_24: select and serial clock inputs synchronised before edge logic.
`timescale 1ns/10ps
`default_nettype none
module spcsd_top #(
   parameter int DATA_W = 8
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   output logic                   irq_req,
   input  wire logic              sck_in,
   output logic                   sck_out,
   output logic                   sck_oe_n,
   input  wire logic              mosi_in,
   output logic                   mosi_out,
   output logic                   mosi_oe_n,
   input  wire logic              miso_in,
   output logic                   miso_out,
   output logic                   miso_oe_n,
   input  wire logic              ss_n_in,
   output logic                   pullup_en
);
   typedef enum logic [2:0] {
      SPCSD_IDLE  = 3'b001,
      SPCSD_LEAD  = 3'b010,
      SPCSD_TRAIL = 3'b100
   } spcsd_state_t;

   logic [7:0]        ctl_reg;
   logic              err_ie_reg, mf_en_reg;
   logic [1:0]        rate_reg;
   logic              rx_full_reg, ovf_reg, mf_reg, tx_empty_reg;
   logic              rx_arm_reg, ovf_arm_reg, mf_arm_reg;
   logic [DATA_W-1:0] rx_buf_reg, tx_buf_reg, shift_reg;
   logic [DATA_W-1:0] reg_rdata_next;
   spcsd_state_t      state_reg;
   logic [3:0]        bit_cnt_reg;
   logic [6:0]        div_cnt_reg;
   logic              sck_reg, mosi_reg, miso_reg, sampled_reg;
   logic [1:0]        ss_sync_reg, sck_sync_reg;
   logic              ss_prev_reg, sck_prev_reg;

   logic enabled, is_master, cpol, cpha, wired_or;
   logic ss_n, sck_s, slave_sel, active, sck_rise, sck_fall, lead_edge, trail_edge;
   logic half_tick, byte_done, tx_load, rd_data, rd_status, wr_data, wr_ctl;
   logic [6:0] half_div;
   logic [DATA_W-1:0] shift_in;

   assign enabled   = ctl_reg[spcsd_pkg::CTL_ENABLE];
   assign is_master = ctl_reg[spcsd_pkg::CTL_MASTER];                       // see RULE_02
   assign cpol      = ctl_reg[spcsd_pkg::CTL_CPOL];
   assign cpha      = ctl_reg[spcsd_pkg::CTL_CPHA];
   assign wired_or  = ctl_reg[spcsd_pkg::CTL_WIRED_OR];
   assign rd_data   = reg_rd && reg_addr == spcsd_pkg::ADDR_DATA;
   assign rd_status = reg_rd && reg_addr == spcsd_pkg::ADDR_STATUS;
   assign wr_data   = reg_wr && reg_addr == spcsd_pkg::ADDR_DATA;
   assign wr_ctl    = reg_wr && reg_addr == spcsd_pkg::ADDR_CONTROL;

   // synchronisers: first stage only feeds the second
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ss_sync_reg  <= 2'h3;
         sck_sync_reg <= 2'h0;
         ss_prev_reg  <= 1'b1;
         sck_prev_reg <= 1'b0;
      end else if (clk_en) begin
         ss_sync_reg  <= {ss_sync_reg[0], ss_n_in};                          // see RULE_24
         sck_sync_reg <= {sck_sync_reg[0], sck_in};                          // see RULE_24
         ss_prev_reg  <= ss_sync_reg[1];
         sck_prev_reg <= sck_sync_reg[1];
      end
   end
   assign ss_n      = ss_sync_reg[1];
   assign sck_s     = sck_sync_reg[1];
   assign slave_sel = enabled && !is_master && !ss_n;
   assign sck_rise  = sck_s && !sck_prev_reg;
   assign sck_fall  = !sck_s && sck_prev_reg;
   // leading edge leaves idle level, trailing returns to it
   assign lead_edge  = slave_sel && (cpol ? sck_fall : sck_rise);           // see RULE_03
   assign trail_edge = slave_sel && (cpol ? sck_rise : sck_fall);           // see RULE_23
   assign active     = state_reg != SPCSD_IDLE;
   assign shift_in   = {shift_reg[DATA_W-2:0], sampled_reg};

   always_comb begin
      case (rate_reg)                                                       // see RULE_20
         2'b00:   half_div = spcsd_pkg::HALF_DIV_0;
         2'b01:   half_div = spcsd_pkg::HALF_DIV_1;
         2'b10:   half_div = spcsd_pkg::HALF_DIV_2;
         default: half_div = spcsd_pkg::HALF_DIV_3;
      endcase
   end
   assign half_tick = is_master && active && div_cnt_reg == half_div - 7'h01;

   // master starts when data waits; slave loads shifter when selected with data waiting
   assign tx_load   = enabled && !active && !tx_empty_reg &&
                      (is_master || slave_sel);                             // see RULE_16

   // control register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_reg <= spcsd_pkg::CTL_RESET;                                   // see RULE_01
      end else if (clk_en) begin
         if (wr_ctl) begin
            ctl_reg <= reg_wdata[7:0] & spcsd_pkg::CTL_MASK;
         end else if (mf_reg && is_master && mf_en_reg && enabled) begin
            // a master fault drops the enable so the pins are released
            ctl_reg[spcsd_pkg::CTL_ENABLE] <= 1'b0;
         end
      end
   end

   // status/control writable fields
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         err_ie_reg <= 1'b0;
         mf_en_reg  <= 1'b0;
         rate_reg   <= 2'h0;
      end else if (clk_en && reg_wr && reg_addr == spcsd_pkg::ADDR_STATUS) begin
         err_ie_reg <= reg_wdata[spcsd_pkg::STS_ERR_IRQ_EN];
         mf_en_reg  <= reg_wdata[spcsd_pkg::STS_MF_EN];
         rate_reg   <= reg_wdata[spcsd_pkg::STS_RATE_HI:spcsd_pkg::STS_RATE_LO];
      end
   end

   // data buffers: never reset
   always_ff @(posedge mclk) begin
      if (clk_en) begin
         if (wr_data) begin
            tx_buf_reg <= reg_wdata;                                        // see RULE_21
         end
         if (byte_done && !rx_full_reg) begin
            rx_buf_reg <= shift_in;                                         // see RULE_11
         end
      end
   end

   // transfer engine; enable low acts as partial reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg   <= SPCSD_IDLE;
         bit_cnt_reg <= 4'h0;
         div_cnt_reg <= 7'h00;
         shift_reg   <= '0;
         sampled_reg <= 1'b0;
         sck_reg     <= 1'b0;
         mosi_reg    <= 1'b0;
         miso_reg    <= 1'b0;
      end else if (clk_en) begin
         if (!enabled || (!is_master && ss_n)) begin                        // see RULE_07
            state_reg   <= SPCSD_IDLE;                                      // see RULE_23
            bit_cnt_reg <= 4'h0;
            div_cnt_reg <= 7'h00;
            sck_reg     <= cpol;
         end else if (tx_load) begin
            state_reg   <= SPCSD_LEAD;
            bit_cnt_reg <= 4'h0;
            div_cnt_reg <= 7'h00;
            shift_reg   <= tx_buf_reg;
            mosi_reg    <= tx_buf_reg[DATA_W-1];
            miso_reg    <= tx_buf_reg[DATA_W-1];
            sck_reg     <= cpol;
         end else if (!active) begin
            // idle clock follows a polarity change before the next frame
            sck_reg     <= cpol;                                            // see RULE_03
         end else if (is_master) begin
            div_cnt_reg <= half_tick ? 7'h00 : div_cnt_reg + 7'h01;
            if (half_tick) begin
               sck_reg <= ~sck_reg;
               case (state_reg)
                  SPCSD_LEAD: begin
                     // phase 1 launches on leading edge, phase 0 samples there
                     if (cpha && bit_cnt_reg != 4'h0) begin                 // see RULE_04
                        shift_reg <= shift_in;
                        mosi_reg  <= shift_in[DATA_W-1];
                     end
                     if (!cpha) sampled_reg <= miso_in;
                     state_reg <= SPCSD_TRAIL;
                  end
                  SPCSD_TRAIL: begin
                     if (cpha) sampled_reg <= miso_in;
                     else if (bit_cnt_reg != 4'(spcsd_pkg::BITS_PER_BYTE - 1)) begin
                        shift_reg <= shift_in;
                        mosi_reg  <= shift_in[DATA_W-1];
                     end
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     state_reg   <= (bit_cnt_reg == 4'(spcsd_pkg::BITS_PER_BYTE - 1)) ?
                                    SPCSD_IDLE : SPCSD_LEAD;                // see RULE_22
                  end
                  default: state_reg <= SPCSD_IDLE;
               endcase
            end
         end else if (active) begin
            if (lead_edge) begin
               if (cpha && bit_cnt_reg != 4'h0) begin
                  shift_reg <= shift_in;
                  miso_reg  <= shift_in[DATA_W-1];
               end
               if (!cpha) sampled_reg <= mosi_in;
            end else if (trail_edge) begin
               if (cpha) sampled_reg <= mosi_in;
               else if (bit_cnt_reg != 4'(spcsd_pkg::BITS_PER_BYTE - 1)) begin
                  shift_reg <= shift_in;
                  miso_reg  <= shift_in[DATA_W-1];
               end
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == 4'(spcsd_pkg::BITS_PER_BYTE - 1)) begin
                  state_reg <= SPCSD_IDLE;
               end
            end
         end
      end
   end
   // with phase 1 the last sample is taken one cycle before completion is seen
   logic done_pend_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         done_pend_reg <= 1'b0;
      end else if (clk_en) begin
         done_pend_reg <= enabled && active && bit_cnt_reg == 4'(spcsd_pkg::BITS_PER_BYTE - 1) &&
                          ((is_master && half_tick && state_reg == SPCSD_TRAIL) ||
                           (!is_master && trail_edge && !ss_n));
      end
   end
   // cpha=1 samples on the final edge, so the byte is complete one cycle later
   assign byte_done = done_pend_reg;

   // status flags; hardware set wins over software clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_full_reg  <= 1'b0;
         ovf_reg      <= 1'b0;
         mf_reg       <= 1'b0;
         tx_empty_reg <= 1'b1;                                              // see RULE_16
         rx_arm_reg   <= 1'b0;
         ovf_arm_reg  <= 1'b0;
         mf_arm_reg   <= 1'b0;
      end else if (clk_en) begin
         if (rd_status) begin
            rx_arm_reg  <= rx_full_reg;
            ovf_arm_reg <= ovf_reg;
            mf_arm_reg  <= mf_reg;
         end
         if (byte_done && !rx_full_reg) rx_full_reg <= 1'b1;                // see RULE_09
         else if (rd_data && rx_arm_reg) rx_full_reg <= 1'b0;               // see RULE_09
         if (byte_done && rx_full_reg) ovf_reg <= 1'b1;                     // see RULE_11
         else if (rd_data && ovf_arm_reg) ovf_reg <= 1'b0;                  // see RULE_12
         if (mf_en_reg && enabled &&                                        // see RULE_19
             ((is_master && !ss_n) ||                                       // see RULE_14
              (!is_master && active && ss_n && !ss_prev_reg)))              // see RULE_13
            mf_reg <= 1'b1;                                                 // see RULE_18
         else if (wr_ctl && mf_arm_reg) mf_reg <= 1'b0;                     // see RULE_15
         if (rd_data) begin
            rx_arm_reg  <= 1'b0;
            ovf_arm_reg <= 1'b0;
         end
         if (wr_ctl) mf_arm_reg <= 1'b0;
         if (tx_load) tx_empty_reg <= 1'b1;                                 // see RULE_16
         else if (wr_data) tx_empty_reg <= 1'b0;                            // see RULE_16
      end
   end

   always_comb begin
      reg_rdata_next = '0;
      case (reg_addr)
         spcsd_pkg::ADDR_CONTROL: reg_rdata_next[7:0] = ctl_reg;
         spcsd_pkg::ADDR_STATUS:  reg_rdata_next[7:0] = {rx_full_reg, err_ie_reg, ovf_reg,
                                                         mf_reg, tx_empty_reg, mf_en_reg,
                                                         rate_reg};
         spcsd_pkg::ADDR_DATA:    reg_rdata_next = rx_buf_reg;              // see RULE_21
         default:                 reg_rdata_next = '0;
      endcase
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? reg_rdata_next : '0;
      end
   end

   // interrupt request is a level that follows flags and enables
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_req <= 1'b0;
      end else if (clk_en) begin
         irq_req <= (ctl_reg[spcsd_pkg::CTL_RX_IRQ_EN] && rx_full_reg) ||    // see RULE_01
                    (ctl_reg[spcsd_pkg::CTL_TX_IRQ_EN] && tx_empty_reg) ||   // see RULE_08
                    (err_ie_reg && (mf_reg || ovf_reg));                     // see RULE_10
      end
   end

   // pins: open drain only ever pulls low, otherwise released
   always_comb begin
      sck_out   = sck_reg;
      mosi_out  = mosi_reg;
      miso_out  = miso_reg;
      sck_oe_n  = 1'b1;
      mosi_oe_n = 1'b1;
      miso_oe_n = 1'b1;
      if (enabled && is_master) begin
         sck_oe_n  = wired_or ? sck_reg : 1'b0;                             // see RULE_06
         mosi_oe_n = wired_or ? mosi_reg : 1'b0;                            // see RULE_06
      end else if (slave_sel) begin
         miso_oe_n = wired_or ? miso_reg : 1'b0;                            // see RULE_23
      end
      if (wired_or) begin
         sck_out  = 1'b0;
         mosi_out = 1'b0;
         miso_out = 1'b0;
      end
   end
   assign pullup_en = !wired_or;                                            // see RULE_06
endmodule
`default_nettype wire
